// file: design/gpls_top.v
// function select for pins 0 to 4 with an axi4-lite register slave
// assumes pins, sequencer and interrupt levels synchronous to core_clk_in
//
// Summary of operation
// - pin 4: gpio, trigger0, sync4, irq1
// - pin 3: gpio, trigger3, sync3, irq0
// - pin 2: por flag, trigger2, sync2, clock
// - pin 1: gpio, trigger1, sync1, hibernate
// - pin 0: irq0, trigger0, sync0, gpio
// - pin 1 hibernate mode shows sleep flag
// - interrupt pin follows interrupt level
// - sync pin follows sequencer only when enabled
`timescale 1ns/1ps
`include "gpls_map.vh"

module gpls_top #(
   parameter AW = 12
) (
   input  wire          core_clk_in,
   input  wire          reset_n_in,
   input  wire [AW-1:0] s_axi_awaddr_in,
   input  wire          s_axi_awvalid_in,
   output wire          s_axi_awready_out,
   input  wire [31:0]   s_axi_wdata_in,
   input  wire [3:0]    s_axi_wstrb_in,
   input  wire          s_axi_wvalid_in,
   output wire          s_axi_wready_out,
   output wire [1:0]    s_axi_bresp_out,
   output wire          s_axi_bvalid_out,
   input  wire          s_axi_bready_in,
   input  wire [AW-1:0] s_axi_araddr_in,
   input  wire          s_axi_arvalid_in,
   output wire          s_axi_arready_out,
   output wire [31:0]   s_axi_rdata_out,
   output wire [1:0]    s_axi_rresp_out,
   output wire          s_axi_rvalid_out,
   input  wire          s_axi_rready_in,
   input  wire [4:0]    pin_in,
   output wire [4:0]    pin_out,
   output wire [4:0]    pin_drive_n_out,
   input  wire [4:0]    gpio_data_in,
   input  wire [4:0]    sequencer_sync_outputs_in,
   input  wire          irq0_in,
   input  wire          irq1_in,
   input  wire          por_flag_in,
   input  wire          hibernate_in,
   output wire [3:0]    seq_trigger_out,
   output wire          external_clock_in_out,
   output wire [15:0]   pin_function_select_out,
   output wire [7:0]    pin_output_enable_out
);

   reg  [15:0]   func_sel_q;
   reg  [7:0]    out_en_q;
   reg           aw_full_q;
   reg  [AW-1:0] awaddr_q;
   reg           w_full_q;
   reg  [31:0]   wdata_q;
   reg  [3:0]    wstrb_q;
   reg           bvalid_q;
   reg  [1:0]    bresp_q;
   reg           rvalid_q;
   reg  [1:0]    rresp_q;
   reg  [31:0]   rdata_q;
   reg  [31:0]   rd_d;
   reg  [1:0]    rresp_d;
   wire          do_wr;
   wire          wr_sel;
   wire          wr_oe;
   wire [4:0]    trig;
   wire [4:0]    drv_n;
   wire [4:0]    pin_val;
   wire          ext_clk;
   wire [31:0]   status;

   ////////////////////////////////////////////////////////////////////////////
   // write channel: address and data taken in either order
   assign s_axi_awready_out = ~aw_full_q;
   assign s_axi_wready_out  = ~w_full_q;
   assign do_wr  = aw_full_q & w_full_q & ~bvalid_q;
   assign wr_sel = awaddr_q == `GPLS_OFS_FUNC_SEL;
   assign wr_oe  = awaddr_q == `GPLS_OFS_OUT_EN;

   always @(posedge core_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         aw_full_q <= 1'b0;
         awaddr_q  <= {AW{1'b0}};
         w_full_q  <= 1'b0;
         wdata_q   <= 32'h00000000;
         wstrb_q   <= 4'h0;
         bvalid_q  <= 1'b0;
         bresp_q   <= `GPLS_RESP_OKAY;
      end else begin
         if (s_axi_awvalid_in && !aw_full_q) begin
            aw_full_q <= 1'b1;
            awaddr_q  <= {s_axi_awaddr_in[AW-1:2], 2'b00};
         end else if (do_wr) begin
            aw_full_q <= 1'b0;
         end
         if (s_axi_wvalid_in && !w_full_q) begin
            w_full_q <= 1'b1;
            wdata_q  <= s_axi_wdata_in;
            wstrb_q  <= s_axi_wstrb_in;
         end else if (do_wr) begin
            w_full_q <= 1'b0;
         end
         if (do_wr) begin
            bvalid_q <= 1'b1;
            bresp_q  <= (wr_sel || wr_oe) ? `GPLS_RESP_OKAY : `GPLS_RESP_SLVERR;
         end else if (s_axi_bready_in) begin
            bvalid_q <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // software registers, byte lanes honoured
   always @(posedge core_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         func_sel_q <= `GPLS_FUNC_SEL_RST;
         out_en_q   <= `GPLS_OUT_EN_RST;
      end else if (do_wr) begin
         if (wr_sel && wstrb_q[0])
            func_sel_q[7:0] <= wdata_q[7:0];
         if (wr_sel && wstrb_q[1])
            func_sel_q[15:8] <= wdata_q[15:8];
         if (wr_oe && wstrb_q[0])
            out_en_q <= wdata_q[7:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // read channel: one outstanding read, unmapped reads zero with slverr
   assign status = {17'h00000, ext_clk, seq_trigger_out, ~drv_n, pin_val};

   always @* begin
      rd_d    = 32'h00000000;
      rresp_d = `GPLS_RESP_OKAY;
      case ({s_axi_araddr_in[AW-1:2], 2'b00})
         `GPLS_OFS_FUNC_SEL: rd_d = {16'h0000, func_sel_q};
         `GPLS_OFS_OUT_EN:   rd_d = {24'h000000, out_en_q};
         `GPLS_OFS_STATUS:   rd_d = status;
         default:            rresp_d = `GPLS_RESP_SLVERR;
      endcase
   end

   assign s_axi_arready_out = ~rvalid_q;

   always @(posedge core_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         rvalid_q <= 1'b0;
         rresp_q  <= `GPLS_RESP_OKAY;
         rdata_q  <= 32'h00000000;
      end else if (s_axi_arvalid_in && !rvalid_q) begin
         rvalid_q <= 1'b1;
         rresp_q  <= rresp_d;
         rdata_q  <= rd_d;
      end else if (s_axi_rready_in) begin
         rvalid_q <= 1'b0;
      end
   end

   assign s_axi_bvalid_out = bvalid_q;
   assign s_axi_bresp_out  = bresp_q;
   assign s_axi_rvalid_out = rvalid_q;
   assign s_axi_rresp_out  = rresp_q;
   assign s_axi_rdata_out  = rdata_q;

   ////////////////////////////////////////////////////////////////////////////
   // per-pin multiplexers; parameters are the code tables
   gpls_pin_mux #(
      .FN0(`GPLS_K_SIG), .FN1(`GPLS_K_TRIG), .FN2(`GPLS_K_SYNC), .FN3(`GPLS_K_GPIO)
   ) u_pin0 (
      .core_clk_in(core_clk_in), .reset_n_in(reset_n_in),
      .sel_in(func_sel_q[`GPLS_PIN0_LSB+1:`GPLS_PIN0_LSB]),
      .pin_in(pin_in[0]), .gpio_data_in(gpio_data_in[0]), .gpio_oe_in(out_en_q[0]),
      .sync_in(sequencer_sync_outputs_in[0]), .sig_in(irq0_in),
      .pin_out(pin_val[0]), .pin_drive_n_out(drv_n[0]), .trig_out(trig[0]), .clk_out()
   );

   gpls_pin_mux #(
      .FN0(`GPLS_K_GPIO), .FN1(`GPLS_K_TRIG), .FN2(`GPLS_K_SYNC), .FN3(`GPLS_K_SIG)
   ) u_pin1 (
      .core_clk_in(core_clk_in), .reset_n_in(reset_n_in),
      .sel_in(func_sel_q[`GPLS_PIN1_LSB+1:`GPLS_PIN1_LSB]),
      .pin_in(pin_in[1]), .gpio_data_in(gpio_data_in[1]), .gpio_oe_in(out_en_q[1]),
      .sync_in(sequencer_sync_outputs_in[1]),
      .sig_in(hibernate_in),
      .pin_out(pin_val[1]), .pin_drive_n_out(drv_n[1]), .trig_out(trig[1]), .clk_out()
   );

   gpls_pin_mux #(
      .FN0(`GPLS_K_SIG), .FN1(`GPLS_K_TRIG), .FN2(`GPLS_K_SYNC), .FN3(`GPLS_K_CLK)
   ) u_pin2 (
      .core_clk_in(core_clk_in), .reset_n_in(reset_n_in),
      .sel_in(func_sel_q[`GPLS_PIN2_LSB+1:`GPLS_PIN2_LSB]),
      .pin_in(pin_in[2]), .gpio_data_in(gpio_data_in[2]), .gpio_oe_in(out_en_q[2]),
      .sync_in(sequencer_sync_outputs_in[2]), .sig_in(por_flag_in),
      .pin_out(pin_val[2]), .pin_drive_n_out(drv_n[2]), .trig_out(trig[2]),
      .clk_out(ext_clk)
   );

   gpls_pin_mux #(
      .FN0(`GPLS_K_GPIO), .FN1(`GPLS_K_TRIG), .FN2(`GPLS_K_SYNC), .FN3(`GPLS_K_SIG)
   ) u_pin3 (
      .core_clk_in(core_clk_in), .reset_n_in(reset_n_in),
      .sel_in(func_sel_q[`GPLS_PIN3_LSB+1:`GPLS_PIN3_LSB]),
      .pin_in(pin_in[3]), .gpio_data_in(gpio_data_in[3]), .gpio_oe_in(out_en_q[3]),
      .sync_in(sequencer_sync_outputs_in[3]), .sig_in(irq0_in),
      .pin_out(pin_val[3]), .pin_drive_n_out(drv_n[3]), .trig_out(trig[3]), .clk_out()
   );

   gpls_pin_mux #(
      .FN0(`GPLS_K_GPIO), .FN1(`GPLS_K_TRIG), .FN2(`GPLS_K_SYNC), .FN3(`GPLS_K_SIG)
   ) u_pin4 (
      .core_clk_in(core_clk_in), .reset_n_in(reset_n_in),
      .sel_in(func_sel_q[`GPLS_PIN4_LSB+1:`GPLS_PIN4_LSB]),
      .pin_in(pin_in[4]), .gpio_data_in(gpio_data_in[4]), .gpio_oe_in(out_en_q[4]),
      .sync_in(sequencer_sync_outputs_in[4]), .sig_in(irq1_in),
      .pin_out(pin_val[4]), .pin_drive_n_out(drv_n[4]), .trig_out(trig[4]), .clk_out()
   );

   ////////////////////////////////////////////////////////////////////////////
   // pins 0 and 4 share sequence 0; either one may start it
   assign seq_trigger_out = {trig[3], trig[2], trig[1], trig[0] | trig[4]};
   assign external_clock_in_out   = ext_clk;
   assign pin_out                 = pin_val;
   assign pin_drive_n_out         = drv_n;
   assign pin_function_select_out = func_sel_q;
   assign pin_output_enable_out   = out_en_q;

endmodule

// file: design/gpls_map.vh
// register map, field positions, reset values and mux kind codes
// assumes inclusion by the pin function select logic only
`ifndef GPLS_MAP_VH
`define GPLS_MAP_VH

////////////////////////////////////////////////////////////////////////////////
// register byte offsets
`define GPLS_OFS_FUNC_SEL   12'h000
`define GPLS_OFS_OUT_EN     12'h004
`define GPLS_OFS_STATUS     12'h024

// reset values
`define GPLS_FUNC_SEL_RST   16'h0000
`define GPLS_OUT_EN_RST     8'h00

// select field positions, two bits each
`define GPLS_PIN0_LSB       0
`define GPLS_PIN1_LSB       2
`define GPLS_PIN2_LSB       4
`define GPLS_PIN3_LSB       6
`define GPLS_PIN4_LSB       8

////////////////////////////////////////////////////////////////////////////////
// what a select code turns a pin into
`define GPLS_K_GPIO         3'h0
`define GPLS_K_TRIG         3'h1
`define GPLS_K_SYNC         3'h2
`define GPLS_K_SIG          3'h3
`define GPLS_K_CLK          3'h4

// axi4-lite responses
`define GPLS_RESP_OKAY      2'h0
`define GPLS_RESP_SLVERR    2'h2

`endif

// file: design/gpls_pin_mux.v
// one pin's function multiplexer, table set by parameters
// assumes select, data and pin levels synchronous to core_clk_in
`timescale 1ns/1ps
`include "gpls_map.vh"

module gpls_pin_mux #(
   parameter [2:0] FN0 = `GPLS_K_GPIO,
   parameter [2:0] FN1 = `GPLS_K_TRIG,
   parameter [2:0] FN2 = `GPLS_K_SYNC,
   parameter [2:0] FN3 = `GPLS_K_SIG
) (
   input  wire       core_clk_in,
   input  wire       reset_n_in,
   input  wire [1:0] sel_in,
   input  wire       pin_in,
   input  wire       gpio_data_in,
   input  wire       gpio_oe_in,
   input  wire       sync_in,
   input  wire       sig_in,
   output wire       pin_out,
   output wire       pin_drive_n_out,
   output wire       trig_out,
   output wire       clk_out
);

   reg [2:0] kind;
   reg       val_d;
   reg       drv_d;
   reg       val_q;
   reg       drv_n_q;
   reg       trig_q;
   reg       clk_q;

   ////////////////////////////////////////////////////////////////////////////
   always @* begin
      case (sel_in)
         2'h0:    kind = FN0;
         2'h1:    kind = FN1;
         2'h2:    kind = FN2;
         default: kind = FN3;
      endcase
   end

   always @* begin
      val_d = 1'b0;
      drv_d = 1'b0;
      case (kind)
         `GPLS_K_GPIO: begin
            val_d = gpio_data_in;
            drv_d = gpio_oe_in;
         end
         `GPLS_K_SYNC: begin
            val_d = sync_in;
            drv_d = gpio_oe_in;
         end
         `GPLS_K_SIG: begin
            // dedicated signals drive regardless of the enable
            val_d = sig_in;
            drv_d = 1'b1;
         end
         default: begin
            val_d = 1'b0;
            drv_d = 1'b0;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   always @(posedge core_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         val_q   <= 1'b0;
         drv_n_q <= 1'b1;
         trig_q  <= 1'b0;
         clk_q   <= 1'b0;
      end else begin
         val_q   <= val_d;
         drv_n_q <= ~drv_d;
         trig_q  <= pin_in & (kind == `GPLS_K_TRIG);
         clk_q   <= pin_in & (kind == `GPLS_K_CLK);
      end
   end

   assign pin_out         = val_q;
   assign pin_drive_n_out = drv_n_q;
   assign trig_out        = trig_q;
   assign clk_out         = clk_q;

endmodule

// file: tb/gpls_props.sv
// checker for pin kinds, trigger and clock gating
// assumes binding to gpls_top, core_clk_in domain only
`timescale 1ns/1ps
module gpls_props (
   input wire        core_clk_in,
   input wire        reset_n_in,
   input wire [4:0]  pin_in,
   input wire [4:0]  pin_out,
   input wire [4:0]  pin_drive_n_out,
   input wire [4:0]  sequencer_sync_outputs_in,
   input wire        irq0_in,
   input wire        irq1_in,
   input wire        por_flag_in,
   input wire        hibernate_in,
   input wire [3:0]  seq_trigger_out,
   input wire        external_clock_in_out,
   input wire [15:0] pin_function_select_out,
   input wire [7:0]  pin_output_enable_out
);
   wire [15:0] fs = pin_function_select_out;
   wire [4:0]  dn = pin_drive_n_out;
   wire [4:0]  po = pin_out;
   wire [7:0]  oe = pin_output_enable_out;
   default clocking @(posedge core_clk_in); endclocking
   default disable iff (!reset_n_in);
   ////////////////////////////////////////////////////////////////////////////////
   // past reset guard: first edge still shows reset values
   AST_PIN0_IRQ: assert property ($past(reset_n_in) && $past(fs[1:0]) == 2'h0 |->
      !dn[0] && po[0] == $past(irq0_in)) else $error("pin0 not irq0");
   AST_PIN2_POR: assert property ($past(reset_n_in) && $past(fs[5:4]) == 2'h0 |->
      !dn[2] && po[2] == $past(por_flag_in)) else $error("pin2 not por");
   AST_PIN1_HIB: assert property ($past(reset_n_in) && $past(fs[3:2]) == 2'h3 |->
      !dn[1] && po[1] == $past(hibernate_in)) else $error("pin1 not sleep flag");
   AST_IRQ_PINS: assert property ($past(reset_n_in) && $past(fs[9:6]) == 4'hF |->
      dn[4:3] == 2'h0 && po[4:3] == {$past(irq1_in), $past(irq0_in)}) else $error("irq pins");
   AST_PIN1_SYNC: assert property ($past(reset_n_in) && $past(fs[3:2]) == 2'h2 |->
      dn[1] == !$past(oe[1]) && (dn[1] || po[1] == $past(sequencer_sync_outputs_in[1])))
      else $error("pin1 sync");
   AST_TRIG0: assert property ($past(reset_n_in) |-> seq_trigger_out[0] ==
      ($past(fs[1:0]) == 2'h1 && $past(pin_in[0]) || $past(fs[9:8]) == 2'h1 && $past(pin_in[4])))
      else $error("trigger 0");
   AST_TRIG3: assert property ($past(reset_n_in) |-> seq_trigger_out[3] ==
      ($past(fs[7:6]) == 2'h1 && $past(pin_in[3]))) else $error("trigger 3");
   AST_CLK: assert property ($past(reset_n_in) |-> external_clock_in_out ==
      ($past(fs[5:4]) == 2'h3 && $past(pin_in[2]))) else $error("clock gate");
endmodule

// file: tb/gpls_host_model.sv
// host side model: pin wires and sleep handshake
// assumes device pin outputs change on core_clk_in
`timescale 1ns/1ps
module gpls_host_model (
   input  wire       core_clk_in,
   input  wire [4:0] pin_out_in,
   input  wire [4:0] pin_drive_n_in,
   input  wire [4:0] host_level_in,
   output wire [4:0] pin_level_out,
   output reg        wake_out,
   output reg        sleep_out
);
   // host lets go wherever the device drives
   assign pin_level_out = (pin_drive_n_in & host_level_in) | (~pin_drive_n_in & pin_out_in);
   // fifo irq on pin 4, sleep flag on pin 1
   always @(posedge core_clk_in) begin
      wake_out  <= pin_out_in[4] & pin_out_in[1];
      sleep_out <= wake_out & ~pin_out_in[4];
   end
endmodule

// file: tb/tb_top.sv
// self-checking bench for the pin function select block
// assumes gpls_top with axi4-lite slave, host model beside it
`timescale 1ns/1ps
module tb_top;
   reg         clk = 1'h0;
   reg         rst_n = 1'h0;
   reg  [11:0] awa = 12'h000;
   reg  [11:0] ara = 12'h000;
   reg  [31:0] wd = 32'h0;
   reg  [3:0]  ws = 4'h0;
   reg         awv = 1'h0, wv = 1'h0, bry = 1'h0, arv = 1'h0, rry = 1'h0;
   reg  [4:0]  hl = 5'h00, gd = 5'h00, sy = 5'h00;
   reg         i0 = 1'h0, i1 = 1'h0, por = 1'h0, hib = 1'h0;
   wire        awr, wr_r, bv, arr, rv, wake, sleep, eclk;
   wire [1:0]  br, rr;
   wire [31:0] rdat;
   wire [4:0]  pi, po, dn;
   wire [3:0]  trig;
   wire [15:0] fs;
   wire [7:0]  oe;
   integer     failures = 0, samples_checked = 0;
   reg  [31:0] rd;
   reg  [1:0]  rs;
   always #4 clk = ~clk;
   gpls_top gpls_top_inst (.core_clk_in(clk), .reset_n_in(rst_n), .s_axi_awaddr_in(awa),
      .s_axi_awvalid_in(awv), .s_axi_awready_out(awr), .s_axi_wdata_in(wd), .s_axi_wstrb_in(ws),
      .s_axi_wvalid_in(wv), .s_axi_wready_out(wr_r), .s_axi_bresp_out(br), .s_axi_bvalid_out(bv),
      .s_axi_bready_in(bry), .s_axi_araddr_in(ara), .s_axi_arvalid_in(arv), .s_axi_arready_out(arr),
      .s_axi_rdata_out(rdat), .s_axi_rresp_out(rr), .s_axi_rvalid_out(rv), .s_axi_rready_in(rry),
      .pin_in(pi), .pin_out(po), .pin_drive_n_out(dn), .gpio_data_in(gd), .sequencer_sync_outputs_in(sy),
      .irq0_in(i0), .irq1_in(i1), .por_flag_in(por), .hibernate_in(hib), .seq_trigger_out(trig),
      .external_clock_in_out(eclk), .pin_function_select_out(fs), .pin_output_enable_out(oe));
   gpls_host_model gpls_host_model_inst (.core_clk_in(clk), .pin_out_in(po), .pin_drive_n_in(dn),
      .host_level_in(hl), .pin_level_out(pi), .wake_out(wake), .sleep_out(sleep));
   ////////////////////////////////////////////////////////////////////////////////
   task chk(input [31:0] g, input [31:0] e);
      begin
         samples_checked = samples_checked + 1;
         if (g !== e) begin
            failures = failures + 1;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
         end
      end
   endtask
   // leading edge keeps two tasks from driving one signal in a step
   task wr(input [11:0] a, input [31:0] d, input [3:0] s);
      begin
         @(posedge clk);
         awa <= a;
         wd  <= d;
         ws  <= s;
         awv <= 1'h1;
         wv  <= 1'h1;
         bry <= 1'h1;
         while (awv || wv || !bv) begin
            @(posedge clk);
            if (awv && awr) awv <= 1'h0;
            if (wv && wr_r) wv <= 1'h0;
         end
         rs = br;
         bry <= 1'h0;
      end
   endtask
   task rdr(input [11:0] a);
      begin
         @(posedge clk);
         ara <= a;
         arv <= 1'h1;
         rry <= 1'h1;
         while (arv || !rv) begin
            @(posedge clk);
            if (arv && arr) arv <= 1'h0;
         end
         rd = rdat;
         rs = rr;
         rry <= 1'h0;
      end
   endtask
   task t_regs;
      begin
         rdr(12'h000);
         chk(rd, 32'h0);
         wr(12'h000, 32'hFFFFFFFF, 4'h1);
         rdr(12'h000);
         chk(rd, 32'h000000FF);
         chk(fs, 16'h00FF);
         wr(12'h004, 32'hFFFFFFFF, 4'hF);
         chk(rs, 2'h0);
         rdr(12'h004);
         chk(rd, 32'h000000FF);
         chk(oe, 8'hFF);
         // pins 0 1 3 4 driving, pin 2 clock input, all levels low
         rdr(12'h024);
         chk(rd, 32'h00000360);
         chk(rs, 2'h0);
         rdr(12'h010);
         chk(rd, 32'h0);
         chk(rs, 2'h2);
         wr(12'h024, 32'h0, 4'hF);
         chk(rs, 2'h2);
         $display("register test done");
      end
   endtask
   // every code of every pin, both levels, enable off and on
   task t_table;
      integer p, c, v, o;
      reg     x, t, s, n;
      begin
         for (o = 0; o < 2; o = o + 1)
            for (v = 0; v < 2; v = v + 1)
               for (p = 0; p < 5; p = p + 1)
                  for (c = 0; c < 4; c = c + 1) begin
                     x = v[0];
                     {gd, sy, hl, i0, i1, por, hib} <= {19{x}};
                     wr(12'h004, {32{o[0]}}, 4'h1);
                     wr(12'h000, c << (2 * p), 4'h3);
                     repeat (2) @(posedge clk);
                     t = (c == 1) || (p == 2 && c == 3);
                     s = (c == 0 && (p == 0 || p == 2)) || (c == 3 && (p == 1 || p > 2));
                     n = t ? 1'h1 : s ? 1'h0 : !o[0];
                     chk(dn[p], n);
                     chk(po[p], t ? 1'h0 : x);
                     chk(trig, c == 1 ? x << (p % 4) : 4'h0);
                     chk(eclk, p == 2 && c == 3 && x);
                  end
         $display("pin table test done");
      end
   endtask
   task t_sleep;
      begin
         wr(12'h000, 32'h000003CC, 4'h3);
         hib <= 1'h0;
         i1  <= 1'h1;
         repeat (4) @(posedge clk);
         chk(wake, 1'h0);
         hib <= 1'h1;
         repeat (3) @(posedge clk);
         chk(wake, 1'h1);
         hib <= 1'h0;
         i1  <= 1'h0;
         repeat (3) @(posedge clk);
         chk(sleep, 1'h1);
         $display("sleep test done");
      end
   endtask
   task give_verdict;
      begin
         $display("checks %0d failures %0d", samples_checked, failures);
         if (failures == 0 && samples_checked > 0)
            $display("NO MISMATCHES");
         else
            $display("MISMATCHES SEEN");
         $finish;
      end
   endtask
   initial begin
      repeat (20) @(posedge clk);
      rst_n <= 1'h1;
      repeat (2) @(posedge clk);
      chk(dn, 5'h1A);
      t_regs;
      t_table;
      t_sleep;
      give_verdict;
   end
   initial begin
      #200000;
      failures = failures + 1;
      give_verdict;
   end
endmodule
bind gpls_top gpls_props gpls_props_inst (.core_clk_in(core_clk_in), .reset_n_in(reset_n_in),
   .pin_in(pin_in), .pin_out(pin_out), .pin_drive_n_out(pin_drive_n_out),
   .sequencer_sync_outputs_in(sequencer_sync_outputs_in), .irq0_in(irq0_in), .irq1_in(irq1_in),
   .por_flag_in(por_flag_in), .hibernate_in(hibernate_in), .seq_trigger_out(seq_trigger_out),
   .external_clock_in_out(external_clock_in_out), .pin_function_select_out(pin_function_select_out),
   .pin_output_enable_out(pin_output_enable_out));
